// [dswm_pkg.sv]
// constants, register map and carrier types for the device sleep/wake manager
// assumes a single-clock host controller with one managed device
package dswm_pkg;
    // how many consecutive MMCs carry a Device Sleep IE or Work IE
    localparam logic [1:0] DSWM_IE_REPEAT = 2'h3;
    // register byte offsets on the Avalon-MM slave
    localparam logic [3:0] DSWM_REG_CTRL = 4'h0;
    localparam logic [3:0] DSWM_REG_STATUS = 4'h4;
    localparam logic [3:0] DSWM_REG_INTERVAL = 4'h8;
    localparam logic [3:0] DSWM_REG_TIMING = 4'hC;
    // control fields
    localparam int DSWM_CTRL_SLEEP_CMD = 0;
    localparam int DSWM_CTRL_STRICT = 1;
    // status fields
    localparam int DSWM_STS_VIEW_SLEEP = 4;
    localparam int DSWM_STS_TRUST_LOST = 5;
    localparam int DSWM_STS_CMD_PEND = 6;
    localparam int DSWM_STS_SCHED_OK = 7;
    // reset values
    localparam logic [15:0] DSWM_INTERVAL_RST = 16'h0010;
    localparam logic [15:0] DSWM_IDLE_RST = 16'h0004;
    localparam logic [15:0] DSWM_LAT_RST = 16'h0010;
    localparam logic [31:0] DSWM_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        DSWM_AWAKE,
        DSWM_DIRECT,
        DSWM_HSLEEP,
        DSWM_RESP,
        DSWM_DSLEEP,
        DSWM_UNAUTH
    } dswm_state_t;

    // notifications received from the device, one-cycle pulses
    typedef struct packed {
        logic sleep;
        logic going;
        logic alive;
        logic reconnect;
    } dswm_ntf_t;

    // information elements to place in the next MMC
    typedef struct packed {
        logic sleep_en;
        logic [15:0] sleep_mmcs;
        logic work_en;
        logic work;
        logic conn_ack;
        logic master_wp;
    } dswm_ie_t;
endpackage : dswm_pkg

// [dswm_manager.sv]
// host-side sleep/wake tracking for one device, with Avalon-MM control registers
// assumes MMC ends, notifications and app state come from logic on CLK_SYS
//
// Operation
// - host directs sleep by placing Device Sleep IE in three consecutive MMCs.
// - each Device Sleep IE names the device and its sleep length.
// - strict flag forces wake latency on every sleep IE, and idle timeout only when directing from awake; else software chooses.
// - host treats device asleep from last IE MMC until interval ends.
// - no transactions scheduled while host views the device asleep.
// - host flags Work Pending in Master MMC, also for sleeping devices.
// - sleeping device polls by sleep notification; host may re-direct sleep.
// - Reconnect Request gets Connect Acknowledge; schedule after re-authentication.
// - DN_Alive before TrustTimeout lets host schedule pending transactions.
// - host marks awake on DN_Alive/Reconnect, or directed interval end.
// - host answers DN_Sleep with Work IE thrice; No Work unless real work.
// - going-to-sleep always means asleep; want-to-sleep only with No Work.
`timescale 1ns/1ps
module dswm_manager
    import dswm_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic MMC_END,
    input wire dswm_pkg::dswm_ntf_t NTF,
    input wire logic APP_WORK,
    input wire logic XACT_DONE,
    input wire logic TRUST_TMO,
    input wire logic AUTH_DONE,
    output dswm_pkg::dswm_ie_t IE,
    output logic SCHED_OK,
    output logic VIEW_SLEEP
);
    import dswm_pkg::*;

    dswm_state_t state;
    dswm_state_t next_state;
    logic [1:0] rep;
    logic [15:0] cnt;
    logic [15:0] sleep_len;
    logic [15:0] idle_cnt;
    logic [15:0] interval;
    logic [15:0] idle_to;
    logic [15:0] wake_lat;
    logic strict;
    logic cmd_pend;
    logic trust_lost;
    logic going;
    logic work_l;
    logic with_sleep;
    logic acc;
    logic wr_ok;
    logic set_cmd;
    logic cmd_taken;
    logic can_direct;
    logic rep_last;
    logic [15:0] next_len;
    logic view;

    // bus handshake: one wait cycle, then the access completes
    assign acc = AVS_READ | AVS_WRITE;
    assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST;
    assign set_cmd = wr_ok && AVS_ADDRESS == DSWM_REG_CTRL && AVS_WRITEDATA[DSWM_CTRL_SLEEP_CMD];
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            AVS_WAITREQUEST <= 1'b1;
        else
            AVS_WAITREQUEST <= ~(acc & AVS_WAITREQUEST);
    end

    // configuration registers
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            strict <= 1'b0;
            interval <= DSWM_INTERVAL_RST;
            idle_to <= DSWM_IDLE_RST;
            wake_lat <= DSWM_LAT_RST;
        end
        else if (wr_ok)
        begin
            if (AVS_ADDRESS == DSWM_REG_CTRL)
                strict <= AVS_WRITEDATA[DSWM_CTRL_STRICT];
            else if (AVS_ADDRESS == DSWM_REG_INTERVAL)
                interval <= AVS_WRITEDATA[15:0];
            else if (AVS_ADDRESS == DSWM_REG_TIMING)
            begin
                idle_to <= AVS_WRITEDATA[15:0];
                wake_lat <= AVS_WRITEDATA[31:16];
            end
        end
    end

    // read data latched in the wait cycle so it stands when waitrequest drops
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            AVS_READDATA <= DSWM_ZERO;
        else if (AVS_READ & AVS_WAITREQUEST)
        begin
            if (AVS_ADDRESS == DSWM_REG_CTRL)
                AVS_READDATA <= {30'h0000_0000, strict, cmd_pend};
            else if (AVS_ADDRESS == DSWM_REG_STATUS)
                AVS_READDATA <= {24'h00_0000, SCHED_OK, cmd_pend, trust_lost, VIEW_SLEEP,
                    1'b0, state};
            else if (AVS_ADDRESS == DSWM_REG_INTERVAL)
                AVS_READDATA <= {16'h0000, interval};
            else if (AVS_ADDRESS == DSWM_REG_TIMING)
                AVS_READDATA <= {wake_lat, idle_to};
            else
                AVS_READDATA <= DSWM_ZERO;
        end
    end

    // idle time in MMCs since the last transaction with the device
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            idle_cnt <= 16'h0000;
        else if (XACT_DONE)
            idle_cnt <= 16'h0000;
        else if (MMC_END && idle_cnt != 16'hFFFF)
            idle_cnt <= idle_cnt + 16'h0001;
    end

    // command is used up only on the entry edge that carries it out; a level
    // clear would swallow a request written while an answer is still running
    assign cmd_taken = (next_state == DSWM_DIRECT && state != DSWM_DIRECT)
        || (next_state == DSWM_RESP && state != DSWM_RESP && !APP_WORK);

    // sleep command: a new request wins over the clear on entry
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            cmd_pend <= 1'b0;
        else
            cmd_pend <= set_cmd | (cmd_pend & ~cmd_taken);
    end

    // trust loss sticks until the device reconnects; a new timeout wins
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            trust_lost <= 1'b0;
        else
            trust_lost <= TRUST_TMO | (trust_lost & ~NTF.reconnect);
    end

    // strict mode waits for idle timeout and uses wake latency as the length
    assign can_direct = cmd_pend && (!strict || idle_cnt >= idle_to);
    assign next_len = strict ? wake_lat : interval;
    assign rep_last = MMC_END && rep == DSWM_IE_REPEAT - 2'h1;

    // power state as the host sees it
    always_comb
    begin
        next_state = state;
        if (NTF.reconnect)
            next_state = DSWM_UNAUTH;
        else
        begin
            case (state)
                DSWM_AWAKE:
                    if (NTF.sleep)
                        next_state = DSWM_RESP;
                    else if (can_direct)
                        next_state = DSWM_DIRECT;
                DSWM_DIRECT:
                    if (rep_last)
                        next_state = DSWM_HSLEEP;
                DSWM_HSLEEP:
                    if (NTF.alive)
                        next_state = DSWM_AWAKE;
                    else if (NTF.sleep)
                        next_state = DSWM_RESP;
                    else if (MMC_END && cnt == 16'h0000)
                        next_state = DSWM_AWAKE;
                DSWM_RESP:
                    if (rep_last)
                    begin
                        if (with_sleep)
                            next_state = DSWM_HSLEEP;
                        else if (going || !work_l)
                            next_state = DSWM_DSLEEP;
                        else
                            next_state = DSWM_AWAKE;
                    end
                DSWM_DSLEEP:
                    if (NTF.alive && !trust_lost)
                        next_state = DSWM_AWAKE;
                    else if (NTF.sleep)
                        next_state = DSWM_RESP;
                DSWM_UNAUTH:
                    if (AUTH_DONE)
                        next_state = DSWM_AWAKE;
                default:
                    next_state = DSWM_AWAKE;
            endcase
        end
    end

    // state, repeat counter, interval counter and response latches
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state <= DSWM_AWAKE;
            rep <= 2'h0;
            cnt <= 16'h0000;
            sleep_len <= 16'h0000;
            going <= 1'b0;
            work_l <= 1'b0;
            with_sleep <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (next_state != state)
                rep <= 2'h0;
            else if (MMC_END)
                rep <= rep + 2'h1;
            if (next_state == DSWM_HSLEEP && state != DSWM_HSLEEP)
                cnt <= sleep_len;
            else if (state == DSWM_HSLEEP && MMC_END && cnt != 16'h0000)
                cnt <= cnt - 16'h0001;
            if (next_state == DSWM_RESP && state != DSWM_RESP)
            begin
                going <= NTF.going;
                work_l <= APP_WORK;
                with_sleep <= cmd_pend & ~APP_WORK;
                sleep_len <= next_len;
            end
            else if (next_state == DSWM_DIRECT && state != DSWM_DIRECT)
                sleep_len <= next_len;
        end
    end

    // host view of sleep; a going-to-sleep answer period already counts
    assign view = state == DSWM_HSLEEP || state == DSWM_DSLEEP
        || (state == DSWM_RESP && (going || !work_l));

    // outputs registered from the current state and the inputs, one cycle behind them
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            IE <= '0;
            SCHED_OK <= 1'b0;
            VIEW_SLEEP <= 1'b0;
        end
        else
        begin
            IE.sleep_en <= state == DSWM_DIRECT || (state == DSWM_RESP && with_sleep);
            IE.sleep_mmcs <= sleep_len;
            IE.work_en <= state == DSWM_RESP;
            IE.work <= work_l;
            IE.conn_ack <= NTF.reconnect;
            IE.master_wp <= APP_WORK;
            SCHED_OK <= !view && state != DSWM_UNAUTH;
            VIEW_SLEEP <= view;
        end
    end

    // checks on the behaviour above
    chk_no_sched_asleep: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        VIEW_SLEEP |-> !SCHED_OK)
        else $error("scheduling allowed while device viewed asleep");
    chk_sleep_ie_len: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        IE.sleep_en |-> IE.sleep_mmcs == $past(sleep_len))
        else $error("sleep IE length differs from latched length");
    chk_direct_three: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == DSWM_DIRECT && rep_last && !NTF.reconnect
        |=> state == DSWM_HSLEEP ##1 !IE.sleep_en)
        else $error("directed sleep did not end after three MMCs");
    chk_master_wp: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        APP_WORK && view |=> IE.master_wp)
        else $error("work pending not flagged for sleeping device");
    chk_alive_wakes: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == DSWM_HSLEEP && NTF.alive && !NTF.reconnect
        |=> state == DSWM_AWAKE ##1 !VIEW_SLEEP)
        else $error("DN_Alive did not end host-directed sleep");
    chk_reconnect_ack: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        NTF.reconnect |=> IE.conn_ack && state == DSWM_UNAUTH ##1 !SCHED_OK)
        else $error("reconnect not acknowledged or scheduled too early");
    chk_interval_end: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == DSWM_HSLEEP && MMC_END && cnt == 16'h0000 && !NTF.sleep && !NTF.reconnect
        |=> state == DSWM_AWAKE)
        else $error("host-directed sleep outlived its interval");
    chk_work_answer: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == DSWM_AWAKE && NTF.sleep && !NTF.reconnect
        |=> ##1 IE.work_en && IE.work == $past(APP_WORK, 2))
        else $error("Work IE does not report queued work");
    chk_strict_len: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        $rose(state == DSWM_DIRECT) && strict && $stable(strict) |-> sleep_len == $past(wake_lat))
        else $error("strict sleep length is not the wake latency");
    chk_want_work: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == DSWM_RESP && rep_last && !going && work_l && !with_sleep && !NTF.reconnect
        |=> state == DSWM_AWAKE)
        else $error("want-to-sleep with work did not stay awake");
    chk_bus_wait: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        acc && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus access not completed after one wait cycle");
endmodule : dswm_manager

// [dswm_device_model.sv]
// device-side partner: sends notifications and follows sleep IEs
// assumes the manager's IE outputs and MMC_END pulses on clk_sys
`timescale 1ns/1ps
module dswm_device_model
    import dswm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic mmc_end,
    input wire dswm_pkg::dswm_ie_t ie,
    output dswm_pkg::dswm_ntf_t ntf
);
    logic asleep = 1'b0;
    logic by_host = 1'b0;
    logic ctrl_open = 1'b0;
    logic sl_d = 1'b0;
    logic [15:0] cnt = 16'h0000;
    initial ntf = '0;
    // one-cycle pulse, launched just after an edge
    task notify(input dswm_ntf_t n);
        @(posedge clk_sys);
        ntf <= n;
        @(posedge clk_sys);
        ntf <= '0;
    endtask : notify
    // a lost answer would leave host and device disagreeing, so retry
    task send_sleep(input logic going);
        int k;
        wait (!ctrl_open);
        for (k = 0; k < 3 && !ie.work_en; k++)
        begin
            notify({1'b1, going, 2'b00});
            repeat (3) @(posedge clk_sys);
        end
        // going sleeps regardless; want sleeps only on a No Work answer
        if (going || (ie.work_en && !ie.work))
        begin
            asleep <= 1'b1;
            by_host <= 1'b0;
        end
    endtask : send_sleep
    // power state as the device sees it
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            asleep <= 1'b0;
            sl_d <= 1'b0;
        end
        else
        begin
            sl_d <= ie.sleep_en;
            if (sl_d && !ie.sleep_en)
            begin
                asleep <= 1'b1;
                by_host <= 1'b1;
                cnt <= ie.sleep_mmcs;
            end
            else if (ntf.alive || ntf.reconnect)
                asleep <= 1'b0;
            else if (asleep && !by_host && ie.master_wp)
                asleep <= 1'b0;
            else if (asleep && by_host && mmc_end)
            begin
                if (cnt == 16'h0000)
                    asleep <= 1'b0;
                cnt <= cnt - 16'h0001;
            end
        end
    end
endmodule : dswm_device_model

// [test_dswm_manager.sv]
// self-checking bench for the sleep/wake manager with a device model
// assumes one 100 MHz clock and the register map of the package
`timescale 1ns/1ps
module test_dswm_manager;
    import dswm_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST_B = 1'b0;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic MMC_END = 1'b0;
    dswm_ntf_t NTF;
    logic APP_WORK = 1'b0;
    logic XACT_DONE = 1'b0;
    logic TRUST_TMO = 1'b0;
    logic AUTH_DONE = 1'b0;
    dswm_ie_t IE;
    logic SCHED_OK;
    logic VIEW_SLEEP;
    int mismatches = 0;
    int compares = 0;
    int len;
    int lat;
    int n;
    int i;
    logic view;
    logic [31:0] q;
    // expected reset image, last entry is an unmapped address
    logic [3:0] ra[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    logic [31:0] rv[5] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0010, 32'h0010_0004,
        32'h0000_0000};
    always #5 CLK_SYS = ~CLK_SYS;
    dswm_manager u_dswm_manager (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .MMC_END(MMC_END), .NTF(NTF),
        .APP_WORK(APP_WORK), .XACT_DONE(XACT_DONE), .TRUST_TMO(TRUST_TMO),
        .AUTH_DONE(AUTH_DONE), .IE(IE), .SCHED_OK(SCHED_OK), .VIEW_SLEEP(VIEW_SLEEP));
    dswm_device_model u_dswm_device_model (.clk_sys(CLK_SYS), .rst_b(RST_B),
        .mmc_end(MMC_END), .ie(IE), .ntf(NTF));
    // one compare, counted
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        do
            @(posedge CLK_SYS);
        while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask : bus
    // mmc ends, outputs settled on return
    task mmc(input int cnt);
        repeat (cnt)
        begin
            @(posedge CLK_SYS);
            MMC_END <= 1'b1;
            @(posedge CLK_SYS);
            MMC_END <= 1'b0;
            @(posedge CLK_SYS);
            #1;
        end
    endtask : mmc
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // hang guard, far beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge CLK_SYS);
        mismatches++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(35526));
        repeat (5) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        // read-only and unmapped writes must leave the image intact
        bus(1'b1, 4'h4, 32'hFFFF_FFFF);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        for (i = 0; i < 5; i++)
        begin
            bus(1'b0, ra[i], 32'h0000_0000);
            chk("reg", q, rv[i]);
        end
        // host-directed sleep with a random interval
        len = 1 + $urandom % 8;
        bus(1'b1, DSWM_REG_INTERVAL, 32'(len));
        bus(1'b1, DSWM_REG_CTRL, 32'h0000_0001);
        repeat (4) @(posedge CLK_SYS);
        #1;
        chk("sleep_en", IE.sleep_en, 1'b1);
        chk("sleep_mmcs", IE.sleep_mmcs, 32'(len));
        mmc(2);
        chk("sleep_en rpt", IE.sleep_en, 1'b1);
        mmc(1);
        chk("sleep_en off", IE.sleep_en, 1'b0);
        chk("view", VIEW_SLEEP, 1'b1);
        chk("sched", SCHED_OK, 1'b0);
        mmc(len);
        chk("view mid", VIEW_SLEEP, 1'b1);
        chk("dev mid", u_dswm_device_model.asleep, 1'b1);
        mmc(1);
        chk("view end", VIEW_SLEEP, 1'b0);
        chk("sched end", SCHED_OK, 1'b1);
        chk("dev end", u_dswm_device_model.asleep, 1'b0);
        // want or going sleep, answered with work or no work
        for (i = 0; i < 4; i++)
        begin
            @(posedge CLK_SYS);
            APP_WORK <= i[0];
            u_dswm_device_model.send_sleep(i[1]);
            chk("work", IE.work, i[0]);
            chk("master_wp", IE.master_wp, i[0]);
            mmc(3);
            view = i[1] | !i[0];
            chk("view ntf", VIEW_SLEEP, view);
            chk("sched ntf", SCHED_OK, !view);
            if (i == 3)
            begin
                @(posedge CLK_SYS);
                TRUST_TMO <= 1'b1;
                @(posedge CLK_SYS);
                TRUST_TMO <= 1'b0;
                u_dswm_device_model.notify(4'h2);
                repeat (2) @(posedge CLK_SYS);
                #1;
                chk("alive late", VIEW_SLEEP, 1'b1);
                u_dswm_device_model.notify(4'h1);
                #1;
                chk("conn_ack", IE.conn_ack, 1'b1);
                @(posedge CLK_SYS);
                #1;
                chk("conn_ack off", IE.conn_ack, 1'b0);
                chk("unauth", SCHED_OK, 1'b0);
                @(posedge CLK_SYS);
                AUTH_DONE <= 1'b1;
                @(posedge CLK_SYS);
                AUTH_DONE <= 1'b0;
            end
            else if (view)
                u_dswm_device_model.notify(4'h2);
            repeat (3) @(posedge CLK_SYS);
            #1;
            chk("sched wake", SCHED_OK, 1'b1);
        end
        // strict timing: wait for idle, latency becomes the interval
        lat = 1 + $urandom % 8;
        bus(1'b1, DSWM_REG_TIMING, {lat[15:0], 16'h0002});
        @(posedge CLK_SYS);
        XACT_DONE <= 1'b1;
        @(posedge CLK_SYS);
        XACT_DONE <= 1'b0;
        bus(1'b1, DSWM_REG_CTRL, 32'h0000_0003);
        n = 0;
        while (IE.sleep_en !== 1'b1 && n < 20)
        begin
            mmc(1);
            n++;
        end
        chk("idle wait", n >= 2 && n < 20, 1'b1);
        chk("strict len", IE.sleep_mmcs, 32'(lat));
        mmc(3);
        chk("strict view", VIEW_SLEEP, 1'b1);
        u_dswm_device_model.notify(4'h2);
        repeat (2) @(posedge CLK_SYS);
        #1;
        chk("early alive", VIEW_SLEEP, 1'b0);
        chk("dev alive", u_dswm_device_model.asleep, 1'b0);
        // poll with a command pending: No Work plus a fresh sleep direction
        @(posedge CLK_SYS);
        XACT_DONE <= 1'b1;
        APP_WORK <= 1'b0;
        @(posedge CLK_SYS);
        XACT_DONE <= 1'b0;
        bus(1'b1, DSWM_REG_CTRL, 32'h0000_0003);
        u_dswm_device_model.send_sleep(1'b0);
        chk("poll sleep_en", IE.sleep_en, 1'b1);
        chk("poll len", IE.sleep_mmcs, 32'(lat));
        mmc(3);
        chk("poll view", VIEW_SLEEP, 1'b1);
        // second poll from directed sleep, no command left
        u_dswm_device_model.send_sleep(1'b0);
        chk("repoll sleep_en", IE.sleep_en, 1'b0);
        mmc(3);
        chk("repoll view", VIEW_SLEEP, 1'b1);
        u_dswm_device_model.notify(4'h2);
        repeat (2) @(posedge CLK_SYS);
        #1;
        chk("poll wake", SCHED_OK, 1'b1);
        give_verdict;
    end
endmodule : test_dswm_manager
